// [inc/swl_params.svh]
// timing constants for the single-wire slot link
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

`define SWL_CLK_MHZ 200
`define SWL_CNT_W 17

// master side times, microseconds, then cycles
`define SWL_RST_LOW_US 480
`define SWL_RST_LOW_CYC (`SWL_RST_LOW_US * `SWL_CLK_MHZ)
`define SWL_PRES_SMP_US 70
`define SWL_PRES_SMP_CYC (`SWL_PRES_SMP_US * `SWL_CLK_MHZ)
`define SWL_SLOT_US 65
`define SWL_SLOT_CYC (`SWL_SLOT_US * `SWL_CLK_MHZ)
`define SWL_WR0_LOW_US 60
`define SWL_WR0_LOW_CYC (`SWL_WR0_LOW_US * `SWL_CLK_MHZ)
`define SWL_WR1_LOW_US 6
`define SWL_WR1_LOW_CYC (`SWL_WR1_LOW_US * `SWL_CLK_MHZ)
`define SWL_RD_INIT_US 1
`define SWL_RD_INIT_CYC (`SWL_RD_INIT_US * `SWL_CLK_MHZ)
`define SWL_RD_SMP_US 12
`define SWL_RD_SMP_CYC (`SWL_RD_SMP_US * `SWL_CLK_MHZ)
`define SWL_RECOV_US 2
`define SWL_RECOV_CYC (`SWL_RECOV_US * `SWL_CLK_MHZ)

// slave side times
`define SWL_RST_DET_US 300
`define SWL_RST_DET_CYC (`SWL_RST_DET_US * `SWL_CLK_MHZ)
`define SWL_PRES_WAIT_US 20
`define SWL_PRES_WAIT_CYC (`SWL_PRES_WAIT_US * `SWL_CLK_MHZ)
`define SWL_PRES_LEN_US 120
`define SWL_PRES_LEN_CYC (`SWL_PRES_LEN_US * `SWL_CLK_MHZ)
`define SWL_WR_SMP_US 20
`define SWL_WR_SMP_CYC (`SWL_WR_SMP_US * `SWL_CLK_MHZ)
`define SWL_RD_HOLD_US 15
`define SWL_RD_HOLD_CYC (`SWL_RD_HOLD_US * `SWL_CLK_MHZ)
`define SWL_SLV_SLOT_US 60
`define SWL_SLV_SLOT_CYC (`SWL_SLV_SLOT_US * `SWL_CLK_MHZ)

// fifo geometry
`define SWL_FIFO_W 10
`define SWL_FIFO_D 4

`endif

// [inc/swl_pkg.sv]
// types and helpers shared by both link ends
package swl_pkg;

    typedef enum logic [1:0] {
        OP_RESET = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ = 2'h2,
        OP_PULLUP = 2'h3
    } swl_op_t;

    typedef enum logic [5:0] {
        M_IDLE = 6'h01,
        M_RST_LOW = 6'h02,
        M_RST_WAIT = 6'h04,
        M_SLOT = 6'h08,
        M_RECOV = 6'h10,
        M_PULLUP = 6'h20
    } swl_mst_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_SLOT = 4'h2,
        S_PWAIT = 4'h4,
        S_PDRV = 4'h8
    } swl_slv_t;

    // crc-8, polynomial x^8+x^5+x^4+1, lsb first
    function automatic logic [7:0] swl_crc8(input logic [7:0] crc,
                                            input logic [7:0] data);
        logic [7:0] c;
        logic fb;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ data[i];
            c = {1'b0, c[7:1]};
            if (fb) begin
                c = c ^ 8'h8c;
            end
        end
        return c;
    endfunction : swl_crc8

endpackage : swl_pkg

// [inc/swl_if.sv]
// shared open-drain data line between master and slave
`timescale 1ns/1ps
interface swl_if;
    logic m_o;
    logic m_oe;
    logic s_o;
    logic s_oe;
    logic strong_pu;
    logic dq;

    // wired-and through the pullup
    assign dq = !((m_oe && !m_o) || (s_oe && !s_o));

    modport master (output m_o, output m_oe, output strong_pu, input dq);
    modport slave (output s_o, output s_oe, input dq, input strong_pu);
endinterface : swl_if

// [src/swl_master.sv]
// bus master end with command fifo
`timescale 1ns/1ps
`include "swl_params.svh"

module swl_fifo #(
    parameter int unsigned W = `SWL_FIFO_W,
    parameter int unsigned D = `SWL_FIFO_D
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : swl_fifo

////////////////////////////////////////////////////////////////////////////

module swl_master #(
    parameter int unsigned RST_LOW_CYC = `SWL_RST_LOW_CYC,
    parameter int unsigned PRES_SMP_CYC = `SWL_PRES_SMP_CYC,
    parameter int unsigned SLOT_CYC = `SWL_SLOT_CYC,
    parameter int unsigned WR0_LOW_CYC = `SWL_WR0_LOW_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // line
    swl_if.master bus,
    // command in
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    // answers
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic presence,
    output logic crc_ok,
    output logic busy
);
    localparam int W = `SWL_CNT_W;
    swl_pkg::swl_mst_t state_q;
    logic [W-1:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic rd_q;
    logic [7:0] crc_q;
    logic low_d;
    logic low_q;
    logic f_valid;
    logic f_ready;
    logic [9:0] f_data;
    swl_pkg::swl_op_t f_op;

    swl_fifo #(.W(`SWL_FIFO_W), .D(`SWL_FIFO_D)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_op, cmd_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign f_op = swl_pkg::swl_op_t'(f_data[9:8]);
    // pullup ends only when the next command arrives
    assign f_ready = (state_q == swl_pkg::M_IDLE)
                  || (state_q == swl_pkg::M_PULLUP);
    assign busy = (state_q != swl_pkg::M_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= swl_pkg::M_IDLE;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            unique case (state_q)
                swl_pkg::M_IDLE, swl_pkg::M_PULLUP: begin
                    cnt_q <= '0;
                    if (f_valid) begin
                        unique case (f_op)
                            swl_pkg::OP_RESET: state_q <= swl_pkg::M_RST_LOW;
                            swl_pkg::OP_PULLUP: state_q <= swl_pkg::M_PULLUP;
                            swl_pkg::OP_WRITE,
                            swl_pkg::OP_READ: state_q <= swl_pkg::M_SLOT;
                        endcase
                    end else if (state_q == swl_pkg::M_PULLUP) begin
                        state_q <= swl_pkg::M_PULLUP;
                    end else begin
                        state_q <= swl_pkg::M_IDLE;
                    end
                end
                swl_pkg::M_RST_LOW: begin
                    if (cnt_q == W'(RST_LOW_CYC - 1)) begin
                        state_q <= swl_pkg::M_RST_WAIT;
                        cnt_q <= '0;
                    end
                end
                swl_pkg::M_RST_WAIT: begin
                    if (cnt_q == W'(RST_LOW_CYC - 1)) begin
                        state_q <= swl_pkg::M_IDLE;
                    end
                end
                swl_pkg::M_SLOT: begin
                    if (cnt_q == W'(SLOT_CYC - 1)) begin
                        state_q <= swl_pkg::M_RECOV;
                        cnt_q <= '0;
                    end
                end
                swl_pkg::M_RECOV: begin
                    if (cnt_q == W'(`SWL_RECOV_CYC - 1)) begin
                        cnt_q <= '0;
                        // eight slots per byte
                        state_q <= (bit_q == 3'h7) ? swl_pkg::M_IDLE
                                                   : swl_pkg::M_SLOT;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit shifting, lsb first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_q <= '0;
            sh_q <= '0;
            rd_q <= 1'b0;
        end else if ((state_q == swl_pkg::M_IDLE
                      || state_q == swl_pkg::M_PULLUP) && f_valid) begin
            bit_q <= '0;
            sh_q <= f_data[7:0];
            rd_q <= (f_op == swl_pkg::OP_READ);
        end else if (state_q == swl_pkg::M_SLOT) begin
            if (rd_q && cnt_q == W'(`SWL_RD_SMP_CYC)) begin
                sh_q <= {bus.dq, sh_q[7:1]};
            end else if (!rd_q && cnt_q == W'(SLOT_CYC - 1)) begin
                sh_q <= {1'b0, sh_q[7:1]};
            end
        end else if (state_q == swl_pkg::M_RECOV
                     && cnt_q == W'(`SWL_RECOV_CYC - 1)) begin
            bit_q <= bit_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line drive: low only, never high
    always_comb begin
        low_d = 1'b0;
        unique case (state_q)
            // a command popped out of pullup opens its slot at once too
            swl_pkg::M_IDLE,
            swl_pkg::M_PULLUP: low_d = f_valid
                                       && f_op != swl_pkg::OP_PULLUP;
            swl_pkg::M_RST_LOW: low_d = (cnt_q != W'(RST_LOW_CYC - 1));
            swl_pkg::M_SLOT: begin
                if (rd_q) begin
                    low_d = (cnt_q < W'(`SWL_RD_INIT_CYC - 1));
                end else if (sh_q[0]) begin
                    low_d = (cnt_q < W'(`SWL_WR1_LOW_CYC - 1));
                end else begin
                    low_d = (cnt_q < W'(WR0_LOW_CYC - 1));
                end
            end
            swl_pkg::M_RECOV: low_d = (cnt_q == W'(`SWL_RECOV_CYC - 1))
                                      && bit_q != 3'h7;
            swl_pkg::M_RST_WAIT: low_d = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            low_q <= 1'b0;
        end else begin
            low_q <= low_d;
        end
    end

    assign bus.m_o = 1'b0;
    assign bus.m_oe = low_q;
    assign bus.strong_pu = (state_q == swl_pkg::M_PULLUP);

    ////////////////////////////////////////////////////////////////////////
    // presence, read data and crc
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presence <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            crc_q <= '0;
            crc_ok <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == swl_pkg::M_RST_LOW) begin
                crc_q <= '0;
                crc_ok <= 1'b0;
            end
            if (state_q == swl_pkg::M_RST_WAIT
                && cnt_q == W'(PRES_SMP_CYC)) begin
                presence <= !bus.dq;
            end
            if (state_q == swl_pkg::M_RECOV && rd_q && bit_q == 3'h7
                && cnt_q == W'(`SWL_RECOV_CYC - 1)) begin
                rsp_valid <= 1'b1;
                rsp_data <= sh_q;
                crc_q <= swl_pkg::swl_crc8(crc_q, sh_q);
                // crc over 8 bytes plus its own byte leaves zero
                crc_ok <= (swl_pkg::swl_crc8(crc_q, sh_q) == 8'h00);
            end
        end
    end
endmodule : swl_master

// [src/swl_slave.sv]
// slave end: presence answer, write sampling, read answering
`timescale 1ns/1ps
`include "swl_params.svh"

// Summary of operation
// - transactions open with reset then presence
// - master holds reset low 480 us minimum
// - slave waits 15-60 us, pulses 60-240 us
// - one bit per slot, both directions
// - write slot 60 us, 1 us recovery
// - write one released within 15 us
// - write zero held low whole slot (master: 60 us of its 65 us slot)
// - slave samples write 15-60 us after edge
// - read slots follow read commands immediately
// - read slots may poll operation progress
// - read slot 60 us, 1 us recovery
// - read slot opens with short low
// - slave pulls low for zero, releases after
// - read data valid 15 us after edge
// - master init, rise, sample under 15 us
// - match command plus 64-bit code addresses
// - strong pullup held during conversion
// - master checks crc over nine bytes
// - master starts every signal except presence
module swl_slave #(
    parameter int unsigned RST_DET_CYC = `SWL_RST_DET_CYC,
    parameter int unsigned PRES_LEN_CYC = `SWL_PRES_LEN_CYC,
    parameter int unsigned SLOT_CYC = `SWL_SLV_SLOT_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // line
    swl_if.slave bus,
    // received bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    // byte to answer in read slots
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // status
    output logic reset_seen
);
    localparam int W = `SWL_CNT_W;
    swl_pkg::swl_slv_t state_q;
    logic [W-1:0] cnt_q;
    logic [W-1:0] low_q;
    logic dq_q;
    logic fall;
    logic rise;
    logic rst_hit;
    logic rst_pend_q;
    logic tx_have_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_bit_q;
    logic [7:0] rx_sh_q;
    logic [2:0] rx_bit_q;
    logic slot_end;
    logic drv_q;
    logic rd_slot_q;

    assign fall = dq_q && !bus.dq;
    assign rise = !dq_q && bus.dq;
    // a low this long can only be a reset pulse
    assign rst_hit = (low_q == W'(RST_DET_CYC - 1)) && !bus.dq;
    assign slot_end = (state_q == swl_pkg::S_SLOT)
                   && (cnt_q == W'(SLOT_CYC - 1));
    assign tx_ready = !tx_have_q;

    ////////////////////////////////////////////////////////////////////////
    // line history
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dq_q <= 1'b1;
            low_q <= '0;
        end else begin
            dq_q <= bus.dq;
            if (bus.dq) begin
                low_q <= '0;
            end else if (low_q != W'(RST_DET_CYC - 1)) begin
                low_q <= low_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= swl_pkg::S_IDLE;
            cnt_q <= '0;
            rst_pend_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            if (rst_hit && state_q != swl_pkg::S_PDRV) begin
                state_q <= swl_pkg::S_IDLE;
                rst_pend_q <= 1'b1;
            end else begin
                unique case (state_q)
                    swl_pkg::S_IDLE: begin
                        cnt_q <= '0;
                        if (rise && rst_pend_q) begin
                            state_q <= swl_pkg::S_PWAIT;
                            rst_pend_q <= 1'b0;
                        end else if (fall && !rst_pend_q) begin
                            state_q <= swl_pkg::S_SLOT;
                        end
                    end
                    swl_pkg::S_SLOT: begin
                        if (slot_end) begin
                            state_q <= swl_pkg::S_IDLE;
                        end
                    end
                    swl_pkg::S_PWAIT: begin
                        if (cnt_q == W'(`SWL_PRES_WAIT_CYC - 1)) begin
                            state_q <= swl_pkg::S_PDRV;
                            cnt_q <= '0;
                        end
                    end
                    swl_pkg::S_PDRV: begin
                        if (cnt_q == W'(PRES_LEN_CYC - 1)) begin
                            state_q <= swl_pkg::S_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= rst_hit && !rst_pend_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write slots: sample inside the window, lsb first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_sh_q <= '0;
            rx_bit_q <= '0;
            rx_valid <= 1'b0;
            rx_data <= '0;
        end else begin
            rx_valid <= 1'b0;
            if (rst_hit) begin
                rx_bit_q <= '0;
            end else if (state_q == swl_pkg::S_SLOT && !rd_slot_q
                         && cnt_q == W'(`SWL_WR_SMP_CYC)) begin
                rx_sh_q <= {bus.dq, rx_sh_q[7:1]};
                rx_bit_q <= rx_bit_q + 1'b1;
                if (rx_bit_q == 3'h7) begin
                    rx_valid <= 1'b1;
                    rx_data <= {bus.dq, rx_sh_q[7:1]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read slots: a loaded byte turns slots into read slots
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_have_q <= 1'b0;
            tx_sh_q <= '0;
            tx_bit_q <= '0;
        end else if (rst_hit) begin
            tx_have_q <= 1'b0; // reset aborts a pending answer
            tx_bit_q <= '0;
        end else if (!tx_have_q) begin
            if (tx_valid) begin
                tx_have_q <= 1'b1;
                tx_sh_q <= tx_data;
                tx_bit_q <= '0;
            end
        end else if (slot_end && rd_slot_q) begin
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 1'b1;
            if (tx_bit_q == 3'h7) begin
                tx_have_q <= 1'b0;
            end
        end
    end

    // slot kind fixed at its falling edge: a byte loaded mid-slot
    // must not lose its first bit at the end of that write slot
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_slot_q <= 1'b0;
        end else if (state_q == swl_pkg::S_IDLE) begin
            rd_slot_q <= tx_have_q;
        end
    end

    // zero pulled low only for the valid window, then released
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= (state_q == swl_pkg::S_PWAIT
                      && cnt_q == W'(`SWL_PRES_WAIT_CYC - 1))
                  || (state_q == swl_pkg::S_PDRV
                      && cnt_q != W'(PRES_LEN_CYC - 1))
                  || (state_q == swl_pkg::S_SLOT && rd_slot_q
                      && !tx_sh_q[0]
                      && cnt_q < W'(`SWL_RD_HOLD_CYC - 1));
        end
    end

    assign bus.s_o = 1'b0;
    assign bus.s_oe = drv_q;
endmodule : swl_slave

// [bench/swl_assertions.sv]
// checker for the shared line between both link ends
`timescale 1ns/1ps
module swl_assertions #(
    parameter int RST_DET = 4600,
    parameter int PRES_LEN = 1000,
    parameter int WR0 = 4400,
    parameter int SLOT = 5000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // line
    input wire logic m_o,
    input wire logic m_oe,
    input wire logic s_o,
    input wire logic s_oe,
    input wire logic strong_pu,
    input wire logic dq
);
    int lo_q, hi_q, rise_q, fall_q, moe_q, per_q, soe_q;
    logic arm_q, pdrv_q;

    ////////////////////////////////////////
    // gap counters start large so the first slot after reset is no fault
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lo_q <= 0;
            hi_q <= 9999;
            rise_q <= 0;
            fall_q <= 0;
            moe_q <= 0;
            per_q <= 99999;
            soe_q <= 0;
            arm_q <= 1'b0;
            pdrv_q <= 1'b0;
        end else begin
            lo_q <= dq ? 0 : lo_q + 1;
            hi_q <= dq ? hi_q + 1 : 0;
            rise_q <= (dq && hi_q == 0) ? 0 : rise_q + 1;
            fall_q <= (!dq && lo_q == 0) ? 0 : fall_q + 1;
            moe_q <= m_oe ? moe_q + 1 : 0;
            per_q <= (m_oe && moe_q == 0) ? 0 : per_q + 1;
            soe_q <= s_oe ? soe_q + 1 : 0;
            if (dq && hi_q == 0 && lo_q >= RST_DET) begin
                arm_q <= 1'b1;
            end else if (s_oe) begin
                arm_q <= 1'b0;
            end
            if (s_oe && arm_q) begin
                pdrv_q <= 1'b1;
            end else if (!s_oe) begin
                pdrv_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence pres_rise;
        $rose(s_oe) && arm_q;
    endsequence

    m_low_only_a: assert property (m_oe |-> !m_o)
        else $error("master drives high");
    s_low_only_a: assert property (s_oe |-> !s_o)
        else $error("slave drives high");
    pres_wait_a: assert property (
        pres_rise |-> rise_q >= 2999 && rise_q <= 12000)
        else $error("presence start off");
    pres_due_a: assert property (arm_q |-> rise_q <= 12001)
        else $error("presence missing");
    pres_len_a: assert property (
        $fell(s_oe) && pdrv_q |-> soe_q >= PRES_LEN - 1
        && soe_q <= PRES_LEN + 1)
        else $error("presence length off");
    rd_hold_a: assert property (
        $fell(s_oe) && !pdrv_q |-> fall_q >= 2400 && fall_q <= 3010)
        else $error("read zero window off");
    follow_a: assert property (
        $rose(s_oe) && !arm_q |-> $past(dq) == 1'b0)
        else $error("slave started a slot");
    low_len_a: assert property (
        $fell(m_oe) |-> (moe_q >= 199 && moe_q < 3000) || moe_q >= WR0 - 1)
        else $error("master low length off");
    recov_a: assert property ($rose(m_oe) |-> hi_q >= 200)
        else $error("recovery too short");
    slot_len_a: assert property ($rose(m_oe) |-> per_q >= SLOT - 1)
        else $error("slot too short");
    pu_quiet_a: assert property (strong_pu |-> !m_oe && !s_oe)
        else $error("line driven under pullup");
endmodule : swl_assertions

// [bench/testbench.sv]
// self-checking bench: master and slave joined over the shared line
`timescale 1ns/1ps
module testbench;
    // shortened counts keep the run near 100k cycles
    localparam int RST_LOW = 5000;
    localparam int RST_DET = 4600;
    // presence must end well before the master's wait does, or the
    // first slot's falling edge merges with the presence low
    localparam int PRES_LEN = 700;
    localparam int SLOT = 5000;
    localparam int WR0 = 4400;
    logic ref_clk, rst, cmd_valid, cmd_ready, rsp_valid, presence, crc_ok;
    logic busy, rx_valid, tx_valid, tx_ready, reset_seen;
    logic [1:0] cmd_op;
    logic [7:0] cmd_data, rsp_data, rx_data, tx_data, wr_b, rd_b, wire_b;
    int failures = 0;
    int compares = 0;
    int run = 0;
    int resets = 0;
    int lows[$];

    swl_if bus_if ();
    swl_master #(.RST_LOW_CYC(RST_LOW), .PRES_SMP_CYC(4500), .SLOT_CYC(SLOT),
        .WR0_LOW_CYC(WR0)) i_swl_master (.ref_clk(ref_clk), .rst(rst),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .presence(presence), .crc_ok(crc_ok),
        .busy(busy));
    swl_slave #(.RST_DET_CYC(RST_DET), .PRES_LEN_CYC(PRES_LEN),
        .SLOT_CYC(4600)) i_swl_slave (.ref_clk(ref_clk), .rst(rst),
        .bus(bus_if), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .reset_seen(reset_seen));
    swl_assertions #(.RST_DET(RST_DET), .PRES_LEN(PRES_LEN), .WR0(WR0),
        .SLOT(SLOT)) i_swl_assertions (.ref_clk(ref_clk), .rst(rst),
        .m_o(bus_if.m_o), .m_oe(bus_if.m_oe), .s_o(bus_if.s_o),
        .s_oe(bus_if.s_oe), .strong_pu(bus_if.strong_pu), .dq(bus_if.dq));

    ////////////////////////////////////////
    task automatic check1(input logic got, input logic exp, input string s);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: %s got %b", $time, s, got);
        end
    endtask : check1

    task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                          input string s);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : check8

    // a one is released inside 15 us, a zero held at least WR0 - 1 cycles of the slot
    function automatic logic low_ok(input logic b, input int len);
        return b ? (len >= 200 && len < 3000) : (len >= WR0 - 1);
    endfunction : low_ok

    task automatic push(input logic [1:0] op, input logic [7:0] d);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        do @(negedge ref_clk); while (cmd_ready !== 1'b1);
        @(posedge ref_clk);
    endtask : push

    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // low time of every master pulse, in order; sampled off the edge
    always @(negedge ref_clk) begin
        if (bus_if.m_oe === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            lows.push_back(run);
            run <= 0;
        end
        if (reset_seen === 1'b1) begin
            resets <= resets + 1;
        end
    end

    initial begin
        repeat (110000) @(posedge ref_clk);
        failures++;
        $display("ERROR %0t: watchdog", $time);
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_data = 8'h00;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        void'($urandom(37));
        // end bits fixed so a reversed bit order shows
        wr_b = {1'b0, 6'($urandom), 1'b1};
        rd_b = {1'b1, 6'($urandom), 1'b0};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check1(bus_if.dq, 1'b1, "idle");
        check1(busy, 1'b0, "not busy");
        @(posedge ref_clk);
        push(2'h0, 8'h00);
        push(2'h1, wr_b);
        push(2'h2, 8'h00);
        push(2'h3, 8'h00);
        push(2'h3, 8'h00);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
        check1(cmd_ready, 1'b0, "fifo full");
        fork
            begin
                do @(negedge ref_clk); while (rx_valid !== 1'b1);
                check8(rx_data, wr_b, "rx");
                @(posedge ref_clk);
                tx_valid <= 1'b1;
                tx_data <= rd_b;
                @(posedge ref_clk);
                tx_valid <= 1'b0;
            end
            begin
                do @(negedge ref_clk); while (rsp_valid !== 1'b1);
            end
        join
        check8(rsp_data, rd_b, "rsp");
        check1(presence, 1'b1, "presence");
        check1(crc_ok, rd_b == 8'h00, "crc");
        repeat (10) @(negedge ref_clk);
        check1(bus_if.strong_pu, 1'b1, "pullup");
        check1(busy, 1'b1, "busy in pullup");
        check1(bus_if.dq, 1'b1, "line");
        check1(tx_ready, 1'b1, "tx free");
        check1(resets == 1, 1'b1, "reset seen");
        check1(lows.size() == 17, 1'b1, "pulses");
        check1(lows[0] >= RST_LOW, 1'b1, "reset low");
        for (int i = 0; i < 8; i++) begin
            wire_b[i] = lows[i + 1] < 3000;
            check1(low_ok(wr_b[i], lows[i + 1]), 1'b1, "wr");
            check1(lows[i + 9] >= 200 && lows[i + 9] < 3000, 1'b1,
                   "rd");
        end
        check8(wire_b, wr_b, "wire");
        wrap_up();
    end
endmodule : testbench
